// [dcp_pkg.sv]
// package: pin bundle, command codes and field positions of the pin block
package dcp_pkg;
    localparam int         DCP_BA_W       = 2;
    localparam int         DCP_ADDR_W     = 14;
    // address bit: auto precharge on rd/wr, all banks on precharge
    localparam int         DCP_A_AP       = 10;
    // extended mode bits
    localparam int         DCP_A_DQSN_DIS = 10;
    localparam int         DCP_A_RDQS_EN  = 11;
    localparam int         DCP_MR_BL_W    = 3;
    localparam logic [2:0] DCP_MR_BL8     = 3'h3;
    localparam logic [3:0] DCP_BL4        = 4'h4;
    localparam logic [3:0] DCP_BL8        = 4'h8;
    localparam logic [1:0] DCP_BA_MR      = 2'h0;
    localparam logic [1:0] DCP_BA_EMR1    = 2'h1;
    localparam logic [13:0] DCP_MR_RST    = 14'h0000;
    localparam logic [13:0] DCP_EMR_RST   = 14'h0000;
    // {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] DCP_CMD_MRS    = 3'h0;
    localparam logic [2:0] DCP_CMD_PRE    = 3'h2;
    localparam logic [2:0] DCP_CMD_ACT    = 3'h3;
    localparam logic [2:0] DCP_CMD_WR     = 3'h4;
    localparam logic [2:0] DCP_CMD_RD     = 3'h5;

    typedef struct packed {
        logic                  cs_n;
        logic                  ras_n;
        logic                  cas_n;
        logic                  we_n;
        logic [DCP_BA_W-1:0]   ba;
        logic [DCP_ADDR_W-1:0] addr;
    } dcp_cmd_pins_t;

    typedef enum {
        DCP_RD_IDLE,
        DCP_RD_PRE,
        DCP_RD_BURST,
        DCP_RD_POST
    } dcp_rd_state_t;
endpackage

// [dcp_ddr2_pins.sv]
// ddr2 device-side command, address, mask and strobe pin logic
// Contract
// - command decoded from ras, cas, we, cs
// - chip select high masks the command
// - masked write beats are not stored
// - mask sampled on both strobe edges
// - x8 mask pin becomes read strobe
// - bank inputs pick the commanded bank
// - bank value picks mode or extended register
// - row on activate, column on rd/wr
// - precharge bit 10 low one, high all
// - single precharge closes only addressed bank
// - mode set loads address as opcode
// - strobe output on reads, input on writes
// - read strobe edge aligned with data
// - x16 lower/upper strobe per data byte
// - one extended bit gates complementary strobes
// - bit 0 differential, bit 1 single-ended
`timescale 1ns/1ns
module dcp_ddr2_pins #(
    parameter bit    X16   = 1'b1,
    parameter int    ROW_W = 2,
    parameter int    COL_W = 4,
    localparam int   DW    = X16 ? 16 : 8,
    localparam int   NS    = X16 ? 2 : 1
) (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic                  ck,
    input  wire dcp_pkg::dcp_cmd_pins_t cmd_i,
    input  wire logic [DW-1:0]         dq_i,
    output logic      [DW-1:0]         dq_o,
    output logic      [DW-1:0]         dq_oe,
    input  wire logic [NS-1:0]         dqs_i,
    output logic      [NS-1:0]         dqs_o,
    output logic      [NS-1:0]         dqs_oe,
    output logic      [NS-1:0]         dqs_n_o,
    output logic      [NS-1:0]         dqs_n_oe,
    input  wire logic [NS-1:0]         dm_i,
    output logic                       rdqs_o,
    output logic                       rdqs_oe,
    output logic                       rdqs_n_o,
    output logic                       rdqs_n_oe,
    output logic      [13:0]           mode_reg_q,
    output logic      [13:0]           ext_mode_reg_q,
    output logic      [3:0]            bank_open_q,
    output logic                       wr_active_q,
    output logic                       rd_active
);
    localparam int NB = 1 << dcp_pkg::DCP_BA_W;
    localparam int IW = dcp_pkg::DCP_BA_W + ROW_W + COL_W;
    localparam int DEPTH = 1 << IW;
    // two-flop synchronisers for everything driven by the controller
    dcp_pkg::dcp_cmd_pins_t cmd_m_q;
    dcp_pkg::dcp_cmd_pins_t cmd_s_q;
    logic                   ck_m_q;
    logic                   ck_s_q;
    logic                   ck_p_q;
    logic [DW-1:0]          dq_m_q;
    logic [DW-1:0]          dq_s_q;
    logic [NS-1:0]          dqs_m_q;
    logic [NS-1:0]          dqs_s_q;
    logic [NS-1:0]          dqs_p_q;
    logic [NS-1:0]          dm_m_q;
    logic [NS-1:0]          dm_s_q;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cmd_m_q <= '1;
            cmd_s_q <= '1;
            ck_m_q  <= 1'b0;
            ck_s_q  <= 1'b0;
            ck_p_q  <= 1'b0;
            dq_m_q  <= '0;
            dq_s_q  <= '0;
            dqs_m_q <= '0;
            dqs_s_q <= '0;
            dqs_p_q <= '0;
            dm_m_q  <= '0;
            dm_s_q  <= '0;
        end else begin
            cmd_m_q <= cmd_i;
            cmd_s_q <= cmd_m_q;
            ck_m_q  <= ck;
            ck_s_q  <= ck_m_q;
            ck_p_q  <= ck_s_q;
            dq_m_q  <= dq_i;
            dq_s_q  <= dq_m_q;
            dqs_m_q <= dqs_i;
            dqs_s_q <= dqs_m_q;
            dqs_p_q <= dqs_s_q;
            dm_m_q  <= dm_i;
            dm_s_q  <= dm_m_q;
        end
    end

    // command decode on the sampled rising edge of ck
    logic [ROW_W-1:0]    row_q [NB];
    logic [IW-1:0]       wr_base_q;
    logic [IW-1:0]       rd_base_q;
    logic [3:0]          rd_cnt_q;
    logic                dqs_q;
    logic                dqs_oe_q;
    logic                dq_oe_q;
    wire  [DW-1:0]       rd_word;
    wire  [NS-1:0]       lane_done;
    dcp_pkg::dcp_rd_state_t rd_st_q;
    wire       ck_rise  = ck_s_q & ~ck_p_q;
    wire       ck_edge  = ck_s_q ^ ck_p_q;
    wire [2:0] cmd_code = {cmd_s_q.ras_n, cmd_s_q.cas_n, cmd_s_q.we_n};
    wire       cmd_take = ck_rise & ~cmd_s_q.cs_n;
    wire       is_mrs   = cmd_take & (cmd_code == dcp_pkg::DCP_CMD_MRS);
    wire       is_pre   = cmd_take & (cmd_code == dcp_pkg::DCP_CMD_PRE);
    wire       is_act   = cmd_take & (cmd_code == dcp_pkg::DCP_CMD_ACT);
    wire       is_wr    = cmd_take & (cmd_code == dcp_pkg::DCP_CMD_WR);
    wire       is_rd    = cmd_take & (cmd_code == dcp_pkg::DCP_CMD_RD);
    wire [1:0] cmd_ba   = cmd_s_q.ba;
    wire       cmd_ap   = cmd_s_q.addr[dcp_pkg::DCP_A_AP];
    // row from the bank's activate, column from the rd/wr itself
    wire [IW-1:0] cmd_idx = {cmd_ba, row_q[cmd_ba],
                             cmd_s_q.addr[COL_W-1:0]};
    wire [3:0] bl = (mode_reg_q[dcp_pkg::DCP_MR_BL_W-1:0]
                     == dcp_pkg::DCP_MR_BL8) ? dcp_pkg::DCP_BL8
                                             : dcp_pkg::DCP_BL4;
    wire rdqs_en = !X16 && ext_mode_reg_q[dcp_pkg::DCP_A_RDQS_EN];
    wire mask_en = !rdqs_en;
    wire dqsn_en = !ext_mode_reg_q[dcp_pkg::DCP_A_DQSN_DIS];
    wire rd_busy = rd_st_q != dcp_pkg::DCP_RD_IDLE;
    // one burst at a time keeps the two ends off the bus together
    wire rd_go   = is_rd & ~rd_busy & ~wr_active_q;
    wire wr_go   = is_wr & ~rd_busy & ~wr_active_q;
    wire rd_step = ck_edge & ((rd_st_q == dcp_pkg::DCP_RD_PRE) |
                   ((rd_st_q == dcp_pkg::DCP_RD_BURST) && rd_cnt_q != bl));
    wire [COL_W-1:0] rd_col = rd_base_q[COL_W-1:0] + rd_cnt_q[COL_W-1:0];
    wire [IW-1:0]    rd_idx = {rd_base_q[IW-1:COL_W], rd_col};
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode_reg_q     <= dcp_pkg::DCP_MR_RST;
            ext_mode_reg_q <= dcp_pkg::DCP_EMR_RST;
        end else if (is_mrs && cmd_ba == dcp_pkg::DCP_BA_MR) begin
            mode_reg_q     <= cmd_s_q.addr;
        end else if (is_mrs && cmd_ba == dcp_pkg::DCP_BA_EMR1) begin
            ext_mode_reg_q <= cmd_s_q.addr;
        end
    end
    // auto precharge is applied at the command; timing is not modelled
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bank_open_q <= '0;
        end else if (is_act) begin
            bank_open_q[cmd_ba] <= 1'b1;
        end else if (is_pre && cmd_ap) begin
            bank_open_q <= '0;
        end else if (is_pre) begin
            bank_open_q[cmd_ba] <= 1'b0;
        end else if ((rd_go | wr_go) && cmd_ap) begin
            bank_open_q[cmd_ba] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int b = 0; b < NB; b++) begin
                row_q[b] <= '0;
            end
        end else if (is_act) begin
            row_q[cmd_ba] <= cmd_s_q.addr[ROW_W-1:0];
        end
    end
    // write burst: each lane counts edges of its own strobe
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_active_q <= 1'b0;
            wr_base_q   <= '0;
        end else if (wr_go) begin
            wr_active_q <= 1'b1;
            wr_base_q   <= cmd_idx;
        end else if (wr_active_q && (&lane_done)) begin
            wr_active_q <= 1'b0;
        end
    end

    for (genvar l = 0; l < NS; l++) begin : g_lane
        logic [7:0] mem_q [DEPTH];
        logic [3:0] cnt_q;
        wire        dqs_edge = dqs_s_q[l] ^ dqs_p_q[l];
        wire        beat     = wr_active_q & dqs_edge & (cnt_q != bl);
        wire [COL_W-1:0] wcol = wr_base_q[COL_W-1:0] + cnt_q[COL_W-1:0];
        wire [IW-1:0]    widx = {wr_base_q[IW-1:COL_W], wcol};
        wire        keep     = !(mask_en && dm_s_q[l]);
        always_ff @(posedge clk_sys) begin
            if (reset) begin
                cnt_q <= '0;
            end else if (wr_go) begin
                cnt_q <= '0;
            end else if (beat) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
        // strobe l owns byte l of the bus
        always_ff @(posedge clk_sys) begin
            if (beat && keep) begin
                mem_q[widx] <= dq_s_q[8*l +: 8];
            end
        end
        assign lane_done[l]      = cnt_q == bl;
        assign rd_word[8*l +: 8] = mem_q[rd_idx];
    end
    // read burst: preamble, one beat per ck edge, postamble
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_st_q   <= dcp_pkg::DCP_RD_IDLE;
            rd_base_q <= '0;
            rd_cnt_q  <= '0;
            dqs_q     <= 1'b0;
            dqs_oe_q  <= 1'b0;
            dq_oe_q   <= 1'b0;
            dq_o      <= '0;
        end else begin
            case (rd_st_q)
                dcp_pkg::DCP_RD_IDLE: begin
                    if (rd_go) begin
                        rd_st_q   <= dcp_pkg::DCP_RD_PRE;
                        rd_base_q <= cmd_idx;
                        rd_cnt_q  <= '0;
                        dqs_q     <= 1'b0;
                        dqs_oe_q  <= 1'b1;
                    end
                end
                dcp_pkg::DCP_RD_PRE,
                dcp_pkg::DCP_RD_BURST: begin
                    if (rd_step) begin
                        rd_st_q  <= dcp_pkg::DCP_RD_BURST;
                        dq_o     <= rd_word;
                        dq_oe_q  <= 1'b1;
                        dqs_q    <= ~dqs_q;
                        rd_cnt_q <= rd_cnt_q + 4'h1;
                    end else if (ck_edge) begin
                        rd_st_q <= dcp_pkg::DCP_RD_POST;
                        dq_oe_q <= 1'b0;
                        dqs_q   <= 1'b0;
                    end
                end
                dcp_pkg::DCP_RD_POST: begin
                    if (ck_edge) begin
                        rd_st_q  <= dcp_pkg::DCP_RD_IDLE;
                        dqs_oe_q <= 1'b0;
                    end
                end
                default: begin
                    rd_st_q <= dcp_pkg::DCP_RD_IDLE;
                end
            endcase
        end
    end
    // strobes and data outputs; lanes share read timing
    assign dq_oe     = {DW{dq_oe_q}};
    assign dqs_o     = {NS{dqs_q}};
    assign dqs_oe    = {NS{dqs_oe_q}};
    assign dqs_n_o   = ~dqs_o;
    assign dqs_n_oe  = dqs_oe & {NS{dqsn_en}};
    assign rdqs_o    = dqs_q;
    assign rdqs_oe   = dqs_oe_q & rdqs_en;
    assign rdqs_n_o  = ~dqs_q;
    assign rdqs_n_oe = rdqs_oe & dqsn_en;
    assign rd_active = rd_busy;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_rd_cmd;
        rd_go;
    endsequence
    sequence s_rd_pre;
        dqs_oe_q && !dqs_q && !dq_oe_q;
    endsequence
    property p_rd_pre;
        s_rd_cmd |=> s_rd_pre;
    endproperty
    a_rd_pre: assert property (p_rd_pre)
        else $error("read preamble not driven");
    property p_rd_align;
        rd_step |=> (dqs_q != $past(dqs_q)) && dq_oe_q && dqs_oe_q;
    endproperty
    a_rd_align: assert property (p_rd_align)
        else $error("read strobe not aligned with data");
    property p_cs_mask;
        ck_rise && cmd_s_q.cs_n |=> $stable(mode_reg_q) &&
            $stable(ext_mode_reg_q) && $stable(bank_open_q);
    endproperty
    a_cs_mask: assert property (p_cs_mask)
        else $error("deselected command took effect");
    property p_mrs_load;
        is_mrs && cmd_ba == dcp_pkg::DCP_BA_MR |=>
            mode_reg_q == $past(cmd_s_q.addr) && $stable(ext_mode_reg_q);
    endproperty
    a_mrs_load: assert property (p_mrs_load)
        else $error("mode register not loaded");
    property p_emrs_load;
        is_mrs && cmd_ba == dcp_pkg::DCP_BA_EMR1 |=>
            ext_mode_reg_q == $past(cmd_s_q.addr) && $stable(mode_reg_q);
    endproperty
    a_emrs_load: assert property (p_emrs_load)
        else $error("extended mode register not selected");
    property p_act_open;
        is_act |=> bank_open_q[$past(cmd_ba)] &&
            row_q[$past(cmd_ba)] == $past(cmd_s_q.addr[ROW_W-1:0]);
    endproperty
    a_act_open: assert property (p_act_open)
        else $error("activate did not open bank");
    property p_pre_all;
        is_pre && cmd_ap |=> bank_open_q == 4'h0;
    endproperty
    a_pre_all: assert property (p_pre_all)
        else $error("precharge all left a bank open");
    property p_pre_one;
        is_pre && !cmd_ap |=> bank_open_q ==
            ($past(bank_open_q) & ~(4'h1 << $past(cmd_ba)));
    endproperty
    a_pre_one: assert property (p_pre_one)
        else $error("single precharge hit wrong bank");
    property p_no_clash;
        wr_active_q |-> !dq_oe_q && !dqs_oe_q;
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("device drives bus during write");
    property p_dqsn;
        dqs_oe_q |-> dqs_n_oe[0] == !ext_mode_reg_q[dcp_pkg::DCP_A_DQSN_DIS];
    endproperty
    a_dqsn: assert property (p_dqsn)
        else $error("complementary strobe enable wrong");
    property p_rdqs_gate;
        rdqs_oe |-> ext_mode_reg_q[dcp_pkg::DCP_A_RDQS_EN] && !X16;
    endproperty
    a_rdqs_gate: assert property (p_rdqs_gate)
        else $error("read strobe driven while disabled");
endmodule

// [dcp_ctrl_model.sv]
// controller model: link clock, command pins and write bursts
`timescale 1ns/1ns
module dcp_ctrl_model (
    input  wire logic              clk_sys,
    output logic                   ck,
    output dcp_pkg::dcp_cmd_pins_t cmd_o,
    output logic [15:0]            dq_o,
    output logic [1:0]             dqs_o,
    output logic [1:0]             dm_o
);
    localparam dcp_pkg::dcp_cmd_pins_t IDLE = {1'b1, 3'h7, 2'h0, 14'h0000};
    logic [1:0] ph_q;

    initial begin
        ck = 1'b0;
        ph_q = 2'h0;
        cmd_o = IDLE;
        dq_o = 16'h0000;
        dqs_o = 2'h0;
        dm_o = 2'h0;
    end

    // ck runs free: read beats are timed by its edges
    always @(negedge clk_sys) begin
        ph_q <= ph_q + 2'h1;
        if (ph_q == 2'h3) begin
            ck <= ~ck;
        end
    end

    // one command per ck period, held across the whole rise
    task automatic send(input logic cs_n, input logic [2:0] op,
                        input logic [1:0] ba, input logic [13:0] a);
        @(negedge ck);
        cmd_o = {cs_n, op, ba, a};
        @(negedge ck);
        cmd_o = IDLE;
    endtask

    // data and mask set two cycles before each strobe edge
    task automatic beats(input logic [63:0] d, input logic [7:0] m,
                         input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            dq_o = d[16*i +: 16];
            dm_o = m[2*i +: 2];
            repeat (2) @(negedge clk_sys);
            dqs_o = ~dqs_o;
            @(negedge clk_sys);
        end
        repeat (2) @(negedge clk_sys);
        // released bus must not look like the last beat
        dq_o = ~dq_o;
        dm_o = ~dm_o;
    endtask
endmodule

// [ddr2_cmd_addr_strobe_pins_tb.sv]
// testbench: commands, masked writes and strobe checks of the pin block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    miscompares++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module ddr2_cmd_addr_strobe_pins_tb;
    logic                   clk_sys;
    logic                   reset;
    logic                   ck;
    dcp_pkg::dcp_cmd_pins_t cmd;
    logic [15:0]            dq_i;
    logic [15:0]            dq_o;
    logic [15:0]            dq_oe;
    logic [1:0]             dqs_i;
    logic [1:0]             dqs_o;
    logic [1:0]             dqs_oe;
    logic [1:0]             dqs_n_o;
    logic [1:0]             dqs_n_oe;
    logic [1:0]             dm_i;
    logic                   rdqs_oe;
    logic [13:0]            mode_reg_q;
    logic [13:0]            ext_mode_reg_q;
    logic [3:0]             bank_open_q;
    logic                   wr_active_q;
    logic                   rd_active;
    logic [7:0]             dq8_o;
    logic                   rdqs8_o;
    logic                   rdqs8_oe;
    logic                   rdqs8_n_oe;
    logic [63:0]            exp_d;
    int                     miscompares = 0;
    int                     checks_done = 0;
    localparam logic [63:0] PAT_A = 64'ha353_a252_a151_a050;
    localparam logic [63:0] PAT_B = 64'hc333_c232_c131_c030;
    localparam logic [7:0]  MASK  = 8'hc9;

    dcp_ddr2_pins i_dut (.clk_sys(clk_sys), .reset(reset), .ck(ck),
        .cmd_i(cmd), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
        .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dqs_n_o(dqs_n_o),
        .dqs_n_oe(dqs_n_oe), .dm_i(dm_i), .rdqs_o(), .rdqs_oe(rdqs_oe),
        .rdqs_n_o(), .rdqs_n_oe(), .mode_reg_q(mode_reg_q),
        .ext_mode_reg_q(ext_mode_reg_q), .bank_open_q(bank_open_q),
        .wr_active_q(wr_active_q), .rd_active(rd_active));

    // x8 twin on the low lane: only it can drive the mask pin strobe
    dcp_ddr2_pins #(.X16(1'b0)) i_dut_x8 (.clk_sys(clk_sys),
        .reset(reset), .ck(ck), .cmd_i(cmd), .dq_i(dq_i[7:0]),
        .dq_o(dq8_o), .dq_oe(), .dqs_i(dqs_i[0]), .dqs_o(), .dqs_oe(),
        .dqs_n_o(), .dqs_n_oe(), .dm_i(dm_i[0]), .rdqs_o(rdqs8_o),
        .rdqs_oe(rdqs8_oe), .rdqs_n_o(), .rdqs_n_oe(rdqs8_n_oe),
        .mode_reg_q(), .ext_mode_reg_q(), .bank_open_q(),
        .wr_active_q(), .rd_active());

    dcp_ctrl_model i_ctrl (.clk_sys(clk_sys), .ck(ck), .cmd_o(cmd),
        .dq_o(dq_i), .dqs_o(dqs_i), .dm_o(dm_i));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // w: 0 write busy, 1 read busy, 2 read strobe of lane 0
    task automatic wait_on(input int w, input logic v);
        for (int k = 0; k < 40; k++) begin
            if ((w == 0 ? wr_active_q : w == 1 ? rd_active : dqs_o[0]) === v)
                return;
            @(negedge clk_sys);
        end
        miscompares++;
        finish_test();
    endtask

    task automatic cmd_go(input logic cs_n, input logic [2:0] op,
                          input logic [1:0] ba, input logic [13:0] a);
        i_ctrl.send(cs_n, op, ba, a);
        repeat (4) @(negedge clk_sys);
    endtask

    task automatic regs(input logic [13:0] m, input logic [13:0] e,
                        input logic [3:0] b);
        `CHK("mode_reg", m, mode_reg_q)
        `CHK("ext_mode_reg", e, ext_mode_reg_q)
        `CHK("bank_open", b, bank_open_q)
    endtask

    task automatic wr(input logic [63:0] d, input logic [7:0] m);
        i_ctrl.send(1'b0, dcp_pkg::DCP_CMD_WR, 2'h0, 14'h0000);
        wait_on(0, 1'b1);
        `CHK("wr_dq_oe", 16'h0000, dq_oe)
        `CHK("wr_dqs_oe", 2'h0, dqs_oe)
        i_ctrl.beats(d, m, 4);
        wait_on(0, 1'b0);
    endtask

    task automatic rd(input logic [13:0] a, input logic [63:0] e,
                      input logic dis);
        i_ctrl.send(1'b0, dcp_pkg::DCP_CMD_RD, 2'h0, a);
        for (int i = 0; i < 4; i++) begin
            wait_on(2, ~i[0]);
            `CHK("rd_dq", e[16*i +: 16], dq_o)
            `CHK("rd_dq_oe", 16'hffff, dq_oe)
            `CHK("rd_dqs", (i[0] ? 2'h0 : 2'h3), dqs_o)
            `CHK("rd_dqs_n", ~dqs_o, dqs_n_o)
            `CHK("dqs_n_oe", (dis ? 2'h0 : 2'h3), dqs_n_oe)
            `CHK("rdqs_oe", 1'b0, rdqs_oe)
            `CHK("rd8_dq", e[16*i +: 8], dq8_o)
            `CHK("rdqs8", ~i[0], rdqs8_o)
            `CHK("rdqs8_oe", ~dis, rdqs8_oe)
            `CHK("rdqs8_n_oe", ~dis, rdqs8_n_oe)
        end
        wait_on(1, 1'b0);
        `CHK("rd_end_dq_oe", 16'h0000, dq_oe)
        `CHK("rd_end_dqs_oe", 2'h0, dqs_oe)
    endtask

    initial begin
        reset = 1'b1;
        repeat (8) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        regs(14'h0000, 14'h0000, 4'h0);
        `CHK("rst_dq_oe", 16'h0000, dq_oe)
        cmd_go(1'b1, dcp_pkg::DCP_CMD_MRS, 2'h0, 14'h0005);
        regs(14'h0000, 14'h0000, 4'h0);
        cmd_go(1'b0, dcp_pkg::DCP_CMD_MRS, 2'h0, 14'h0002);
        regs(14'h0002, 14'h0000, 4'h0);
        cmd_go(1'b0, dcp_pkg::DCP_CMD_MRS, 2'h1, 14'h0400);
        regs(14'h0002, 14'h0400, 4'h0);
        cmd_go(1'b0, dcp_pkg::DCP_CMD_MRS, 2'h2, 14'h1234);
        regs(14'h0002, 14'h0400, 4'h0);
        cmd_go(1'b0, dcp_pkg::DCP_CMD_ACT, 2'h1, 14'h0001);
        cmd_go(1'b0, dcp_pkg::DCP_CMD_ACT, 2'h2, 14'h0002);
        regs(14'h0002, 14'h0400, 4'h6);
        cmd_go(1'b1, dcp_pkg::DCP_CMD_ACT, 2'h3, 14'h0000);
        regs(14'h0002, 14'h0400, 4'h6);
        cmd_go(1'b0, dcp_pkg::DCP_CMD_PRE, 2'h1, 14'h0000);
        regs(14'h0002, 14'h0400, 4'h4);
        cmd_go(1'b0, dcp_pkg::DCP_CMD_ACT, 2'h0, 14'h0000);
        cmd_go(1'b0, dcp_pkg::DCP_CMD_ACT, 2'h3, 14'h0000);
        regs(14'h0002, 14'h0400, 4'hd);
        cmd_go(1'b0, dcp_pkg::DCP_CMD_PRE, 2'h0, 14'h0400);
        regs(14'h0002, 14'h0400, 4'h0);
        cmd_go(1'b0, dcp_pkg::DCP_CMD_ACT, 2'h0, 14'h0000);
        wr(PAT_A, 8'h00);
        wr(PAT_B, MASK);
        // masked lanes keep the first burst, others take the second
        for (int i = 0; i < 8; i++)
            exp_d[8*i +: 8] = MASK[i] ? PAT_A[8*i +: 8] : PAT_B[8*i +: 8];
        rd(14'h0000, exp_d, 1'b1);
        // complementary strobes on, x8 read strobe on
        cmd_go(1'b0, dcp_pkg::DCP_CMD_MRS, 2'h1, 14'h0800);
        rd(14'h0400, exp_d, 1'b0);
        repeat (4) @(negedge clk_sys);
        regs(14'h0002, 14'h0800, 4'h0);
        finish_test();
    end
endmodule
